//--- hdl/sppv_defs.svh
// Constants of the serial program/verify port
`ifndef SPPV_DEFS_SVH
`define SPPV_DEFS_SVH

`define SPPV_CMD_W          4
`define SPPV_OP_W           16
`define SPPV_PTR_W          22
`define SPPV_CNT_W          5
`define SPPV_CMD_LAST_BIT   5'h03
`define SPPV_HOLD_ARM_BIT   5'h02
`define SPPV_OUT_FIRST_BIT  5'h0c
`define SPPV_FRAME_LAST_BIT 5'h13
`define SPPV_CNT_ZERO       5'h00
`define SPPV_CNT_ONE        5'h01

`define SPPV_CMD_CORE       4'h0
`define SPPV_CMD_SHIFT_LAT  4'h2
`define SPPV_CMD_RD         4'h8
`define SPPV_CMD_RD_INC     4'h9
`define SPPV_CMD_RD_DEC     4'ha
`define SPPV_CMD_RD_PRE     4'hb
`define SPPV_CMD_WR         4'hc
`define SPPV_CMD_WR_INC     4'hd
`define SPPV_CMD_WR_DEC     4'he
`define SPPV_CMD_WR_PROG    4'hf
`define SPPV_CMD_RD_CLASS   2'h2
`define SPPV_CMD_WR_CLASS   2'h3

`define SPPV_RAM_ADDR_W     12
`define SPPV_RAM_PTR_LOW    12'hff6
`define SPPV_RAM_PTR_HIGH   12'hff7
`define SPPV_RAM_PTR_UPPER  12'hff8

`define SPPV_PTR_ONE        22'h00_0001
`define SPPV_PTR_TWO        22'h00_0002
`define SPPV_BOOT_LAST      22'h00_07ff
`define SPPV_CODE_TOP       22'h00_ffff
`define SPPV_CODE_END_48K   22'h00_bfff
`define SPPV_CODE_END_64K   22'h00_ffff
`define SPPV_ID_FIRST       22'h20_0000
`define SPPV_ID_LAST        22'h20_0007
`define SPPV_CFG_FIRST      22'h30_0000
`define SPPV_CFG_LAST       22'h30_000d
`define SPPV_DEVID_LOW      22'h3f_fffe
`define SPPV_DEVID_HIGH     22'h3f_ffff
`define SPPV_BLOCK_MSB      15
`define SPPV_BLOCK_LSB      14
`define SPPV_PANEL_LSB      13
`define SPPV_UPPER_W        6

`define SPPV_SY_DATA        0
`define SPPV_SY_CLK         1
`define SPPV_SY_SEL         2
`define SPPV_SY_LOGIC       3
`define SPPV_SY_HIGH        4
`define SPPV_SY_REQ         5
`define SPPV_SY_HOLD        6
`define SPPV_SY_W           7

`endif

//--- hdl/sppv_pkg.sv
// Types of the serial program/verify port
package sppv_pkg;
	typedef enum logic [1:0] {
		SPPV_M_OFF = 2'h0,
		SPPV_M_HV  = 2'h1,
		SPPV_M_LV  = 2'h2
	} sppv_mode_type;

	typedef enum logic [1:0] {
		SPPV_C_IDLE = 2'h0,
		SPPV_C_READ = 2'h1,
		SPPV_C_WAIT = 2'h3,
		SPPV_C_ACK  = 2'h2
	} sppv_core_state_type;
endpackage

//--- hdl/sppv_sync.sv
// Two-flop level synchroniser, one per bit
`timescale 1ns/1ps
module sppv_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_q;

	generate
		if (WIDTH < 1) begin : g_chk
			$error("sppv_sync needs at least one bit");
		end
	endgenerate

	// First stage feeds nothing but the second
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			meta_q <= '0;
			o_sync <= '0;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule

//--- hdl/sppv_port.sv
// Serial program/verify port: mode entry, serial shifter, table engine
// How it works
// - High entry: clock, data low, enable high
// - Low entry needs config bit, select pin
// - Low mode dedicates select pin to programming
// - Entering mode floats all unused pins
// - Capture falling edge, launch rising, LSb first
// - Frame is 4-bit command, 16-bit operand
// - Command takes exactly four clocks
// - Reads: 8 bits in, 8 bits out
// - Command 0000 executes operand on core
// - Read command decode with pointer steps
// - Write command decode with pointer steps
// - Pointer built from upper, high, low bytes
// - Pointer bytes live at RAM 0FF6h-0FF8h
// - ID bytes readable despite code protection
// - Configuration bytes readable despite protection
// - Device ID readable at top two bytes
// - 16K protection blocks plus boot block
// - Programming panels on 8K boundaries
// - Code memory ends per variant size
// - Fourth clock high after start times programming
`timescale 1ns/1ps
`include "sppv_defs.svh"
module sppv_port
	import sppv_pkg::*;
#(
	parameter logic [`SPPV_PTR_W-1:0] CODE_END  = `SPPV_CODE_END_64K,
	// Arbitrary identification value
	parameter logic [`SPPV_OP_W-1:0]  DEVICE_ID = 16'h5a5a
) (
	input  wire logic                        i_core_clk,
	input  wire logic                        i_rst_n,
	input  wire logic                        i_serial_prog_clock,
	input  wire logic                        i_serial_prog_data,
	output logic                             o_serial_prog_data,
	output logic                             o_serial_prog_data_oe,
	input  wire logic                        i_prog_enable_high,
	input  wire logic                        i_prog_enable_logic,
	input  wire logic                        i_lowvolt_select_pin,
	input  wire logic                        i_lowvolt_enable_bit,
	input  wire logic [4:0]                  i_code_protect,
	output logic                             o_prog_mode,
	output logic                             o_lowvolt_mode,
	output logic                             o_unused_io_hiz,
	output logic                             o_lowvolt_pin_dedicated,
	output logic                             o_core_exec,
	output logic [`SPPV_OP_W-1:0]            o_core_instr,
	input  wire logic                        i_ram_wr,
	input  wire logic [`SPPV_RAM_ADDR_W-1:0] i_ram_addr,
	input  wire logic [7:0]                  i_ram_wdata,
	output logic [7:0]                       o_ram_rdata,
	output logic [`SPPV_PTR_W-1:0]           o_table_ptr,
	output logic [`SPPV_PTR_W-1:0]           o_mem_addr,
	output logic [2:0]                       o_panel,
	output logic                             o_mem_rd,
	input  wire logic [7:0]                  i_mem_rdata,
	input  wire logic                        i_mem_rd_valid,
	output logic                             o_mem_wr,
	output logic [`SPPV_OP_W-1:0]            o_mem_wdata,
	output logic                             o_prog_start,
	output logic                             o_programming
);
	generate
		if (CODE_END != `SPPV_CODE_END_48K && CODE_END != `SPPV_CODE_END_64K) begin : g_chk
			$error("CODE_END must be the 48K or 64K code end");
		end
	endgenerate

	// Core-domain pin synchronisers and mode state
	logic [`SPPV_SY_W-1:0] sy_raw;
	logic [`SPPV_SY_W-1:0] sy;
	logic                  high_prev_q;
	logic                  logic_prev_q;
	sppv_mode_type         mode_q;
	sppv_mode_type         mode_d;

	// Link-domain state
	logic                  link_rst_n;
	logic [`SPPV_CNT_W-1:0] bit_cnt_q;
	logic [`SPPV_CMD_W-1:0] cmd_q;
	logic [`SPPV_OP_W-1:0]  op_q;
	logic                  req_tgl_q;
	logic [`SPPV_CMD_W-1:0] req_cmd_q;
	logic [`SPPV_OP_W-1:0]  req_op_q;
	logic                  prog_armed_q;
	logic                  hold_win_q;
	logic                  ack_sync;
	logic                  ack_seen_q;
	logic [7:0]            out_q;

	// Core-domain table engine
	sppv_core_state_type   cst_q;
	sppv_core_state_type   cst_d;
	logic                  req_seen_q;
	logic                  ack_tgl_q;
	logic [`SPPV_PTR_W-1:0] ptr_q;
	logic [`SPPV_PTR_W-1:0] ptr_d;
	logic [7:0]            table_latch_q;

	assign sy_raw = {hold_win_q, req_tgl_q, i_prog_enable_high, i_prog_enable_logic,
		i_lowvolt_select_pin, i_serial_prog_clock, i_serial_prog_data};

	sppv_sync #(
		.WIDTH (`SPPV_SY_W)
	) u_core_sync (
		.i_clk   (i_core_clk),
		.i_rst_n (i_rst_n),
		.i_async (sy_raw),
		.o_sync  (sy)
	);

	wire lines_low  = !sy[`SPPV_SY_CLK] && !sy[`SPPV_SY_DATA];
	wire high_rise  = sy[`SPPV_SY_HIGH] && !high_prev_q;
	wire logic_rise = sy[`SPPV_SY_LOGIC] && !logic_prev_q;

	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			SPPV_M_OFF: begin
				if (high_rise && lines_low) begin
					mode_d = SPPV_M_HV;
				end else if (i_lowvolt_enable_bit && sy[`SPPV_SY_SEL] && logic_rise
						&& lines_low) begin
					mode_d = SPPV_M_LV;
				end
			end
			SPPV_M_HV: begin
				if (!sy[`SPPV_SY_HIGH]) begin
					mode_d = SPPV_M_OFF;
				end
			end
			SPPV_M_LV: begin
				if (!sy[`SPPV_SY_LOGIC]) begin
					mode_d = SPPV_M_OFF;
				end
			end
			default: mode_d = SPPV_M_OFF;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			mode_q       <= SPPV_M_OFF;
			high_prev_q  <= 1'b0;
			logic_prev_q <= 1'b0;
		end else begin
			mode_q       <= mode_d;
			high_prev_q  <= sy[`SPPV_SY_HIGH];
			logic_prev_q <= sy[`SPPV_SY_LOGIC];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_prog_mode             <= 1'b0;
			o_lowvolt_mode          <= 1'b0;
			o_unused_io_hiz         <= 1'b0;
			o_lowvolt_pin_dedicated <= 1'b0;
			o_programming           <= 1'b0;
		end else begin
			o_prog_mode             <= mode_d != SPPV_M_OFF;
			o_lowvolt_mode          <= mode_d == SPPV_M_LV;
			o_unused_io_hiz         <= mode_d != SPPV_M_OFF;
			o_lowvolt_pin_dedicated <= mode_d == SPPV_M_LV;
			o_programming           <= o_prog_mode && sy[`SPPV_SY_CLK] && sy[`SPPV_SY_HOLD];
		end
	end

	// Link logic is held in reset outside the mode; clock idles low at entry
	assign link_rst_n = o_prog_mode;

	wire [`SPPV_CMD_W-1:0] cmd_full = {i_serial_prog_data, cmd_q[2:0]};
	wire [`SPPV_OP_W-1:0]  op_full  = {i_serial_prog_data, op_q[`SPPV_OP_W-2:0]};
	wire in_cmd     = bit_cnt_q <= `SPPV_CMD_LAST_BIT;
	wire cmd_done   = bit_cnt_q == `SPPV_CMD_LAST_BIT;
	wire frame_done = bit_cnt_q == `SPPV_FRAME_LAST_BIT;
	wire [`SPPV_CNT_W-1:0] op_idx = bit_cnt_q - `SPPV_CMD_LAST_BIT - `SPPV_CNT_ONE;
	wire full_is_rd = cmd_full[3:2] == `SPPV_CMD_RD_CLASS || cmd_full == `SPPV_CMD_SHIFT_LAT;
	wire cur_is_rd  = cmd_q[3:2] == `SPPV_CMD_RD_CLASS || cmd_q == `SPPV_CMD_SHIFT_LAT;

	always_ff @(negedge i_serial_prog_clock or negedge link_rst_n) begin
		if (!link_rst_n) begin
			bit_cnt_q <= `SPPV_CNT_ZERO;
			cmd_q     <= '0;
			op_q      <= '0;
		end else begin
			bit_cnt_q <= frame_done ? `SPPV_CNT_ZERO : bit_cnt_q + `SPPV_CNT_ONE;
			if (in_cmd) begin
				cmd_q[bit_cnt_q[1:0]] <= i_serial_prog_data;
			end else begin
				op_q[op_idx[3:0]] <= i_serial_prog_data;
			end
		end
	end

	// Requests cross as a toggle; command and operand are held until the next
	always_ff @(negedge i_serial_prog_clock or negedge link_rst_n) begin
		if (!link_rst_n) begin
			req_tgl_q <= 1'b0;
			req_cmd_q <= '0;
			req_op_q  <= '0;
		end else if (cmd_done && full_is_rd) begin
			req_tgl_q <= !req_tgl_q;
			req_cmd_q <= cmd_full;
		end else if (frame_done && !cur_is_rd) begin
			req_tgl_q <= !req_tgl_q;
			req_cmd_q <= cmd_q;
			req_op_q  <= op_full;
		end
	end

	always_ff @(negedge i_serial_prog_clock or negedge link_rst_n) begin
		if (!link_rst_n) begin
			prog_armed_q <= 1'b0;
			hold_win_q   <= 1'b0;
		end else begin
			if (frame_done && cmd_q == `SPPV_CMD_WR_PROG) begin
				prog_armed_q <= 1'b1;
			end else if (cmd_done) begin
				prog_armed_q <= 1'b0;
			end
			hold_win_q <= prog_armed_q && bit_cnt_q == `SPPV_HOLD_ARM_BIT;
		end
	end

	sppv_sync #(
		.WIDTH (1)
	) u_link_sync (
		.i_clk   (i_serial_prog_clock),
		.i_rst_n (link_rst_n),
		.i_async (ack_tgl_q),
		.o_sync  (ack_sync)
	);

	wire drive_out = cur_is_rd && bit_cnt_q >= `SPPV_OUT_FIRST_BIT;
	wire [`SPPV_CNT_W-1:0] out_idx = bit_cnt_q - `SPPV_OUT_FIRST_BIT;

	always_ff @(posedge i_serial_prog_clock or negedge link_rst_n) begin
		if (!link_rst_n) begin
			ack_seen_q            <= 1'b0;
			out_q                 <= '0;
			o_serial_prog_data    <= 1'b0;
			o_serial_prog_data_oe <= 1'b0;
		end else begin
			// Latch is stable once the answer toggle has crossed
			if (ack_sync != ack_seen_q) begin
				ack_seen_q <= ack_sync;
				out_q      <= table_latch_q;
			end
			o_serial_prog_data    <= drive_out && out_q[out_idx[2:0]];
			o_serial_prog_data_oe <= drive_out;
		end
	end

	// Table engine in the core domain
	// Mode gate: a link reset clears the toggle, which is no request
	wire req_edge = o_prog_mode && sy[`SPPV_SY_REQ] != req_seen_q;
	wire go       = cst_q == SPPV_C_IDLE && req_edge;
	wire req_rd   = req_cmd_q[3:2] == `SPPV_CMD_RD_CLASS;
	wire req_wr   = req_cmd_q[3:2] == `SPPV_CMD_WR_CLASS;

	wire is_code  = ptr_q <= `SPPV_CODE_TOP;
	wire is_impl  = ptr_q <= CODE_END;
	wire is_boot  = ptr_q <= `SPPV_BOOT_LAST;
	wire [2:0] blk_idx = {1'b0, ptr_q[`SPPV_BLOCK_MSB:`SPPV_BLOCK_LSB]} + 3'h1;
	wire locked   = is_boot ? i_code_protect[0] : i_code_protect[blk_idx];
	wire code_bar = is_code && (!is_impl || locked);
	wire [`SPPV_PTR_W-1:0] devid_base = `SPPV_DEVID_LOW;
	wire is_devid = ptr_q[`SPPV_PTR_W-1:1] == devid_base[`SPPV_PTR_W-1:1];
	wire [7:0] devid_byte = ptr_q[0] ? DEVICE_ID[15:8] : DEVICE_ID[7:0];
	wire rd_local = is_devid || code_bar;
	wire rd_done  = cst_q == SPPV_C_WAIT && (rd_local || i_mem_rd_valid);
	wire wr_go    = go && req_wr && !code_bar;

	always_comb begin
		cst_d = cst_q;
		case (cst_q)
			SPPV_C_IDLE: begin
				if (req_edge) begin
					cst_d = req_rd ? SPPV_C_READ : SPPV_C_ACK;
				end
			end
			SPPV_C_READ: cst_d = SPPV_C_WAIT;
			SPPV_C_WAIT: begin
				if (rd_done) begin
					cst_d = SPPV_C_ACK;
				end
			end
			SPPV_C_ACK: cst_d = SPPV_C_IDLE;
			default: cst_d = SPPV_C_IDLE;
		endcase
	end

	wire [`SPPV_PTR_W-1:0] ptr_inc  = ptr_q + `SPPV_PTR_ONE;
	wire [`SPPV_PTR_W-1:0] ptr_dec  = ptr_q - `SPPV_PTR_ONE;
	wire [`SPPV_PTR_W-1:0] ptr_inc2 = ptr_q + `SPPV_PTR_TWO;
	wire [`SPPV_PTR_W-1:0] ptr_dec2 = ptr_q - `SPPV_PTR_TWO;

	always_comb begin
		ptr_d = ptr_q;
		if (go && req_cmd_q == `SPPV_CMD_RD_PRE) begin
			ptr_d = ptr_inc;
		end else if (rd_done && req_cmd_q == `SPPV_CMD_RD_INC) begin
			ptr_d = ptr_inc;
		end else if (rd_done && req_cmd_q == `SPPV_CMD_RD_DEC) begin
			ptr_d = ptr_dec;
		end else if (go && req_cmd_q == `SPPV_CMD_WR_INC) begin
			ptr_d = ptr_inc2;
		end else if (go && req_cmd_q == `SPPV_CMD_WR_DEC) begin
			ptr_d = ptr_dec2;
		end
	end

	wire hit_low   = i_ram_addr == `SPPV_RAM_PTR_LOW;
	wire hit_high  = i_ram_addr == `SPPV_RAM_PTR_HIGH;
	wire hit_upper = i_ram_addr == `SPPV_RAM_PTR_UPPER;
	wire [7:0] ram_rd = hit_low ? ptr_q[7:0]
		: hit_high ? ptr_q[15:8]
		: hit_upper ? {2'h0, ptr_q[`SPPV_PTR_W-1:16]}
		: 8'h00;

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			ptr_q <= '0;
		end else if (i_ram_wr && hit_low) begin
			ptr_q[7:0] <= i_ram_wdata;
		end else if (i_ram_wr && hit_high) begin
			ptr_q[15:8] <= i_ram_wdata;
		end else if (i_ram_wr && hit_upper) begin
			ptr_q[`SPPV_PTR_W-1:16] <= i_ram_wdata[`SPPV_UPPER_W-1:0];
		end else begin
			ptr_q <= ptr_d;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			cst_q         <= SPPV_C_IDLE;
			req_seen_q    <= 1'b0;
			ack_tgl_q     <= 1'b0;
			table_latch_q <= '0;
		end else begin
			cst_q <= cst_d;
			if (cst_q == SPPV_C_IDLE) begin
				req_seen_q <= sy[`SPPV_SY_REQ];
			end
			if (cst_q == SPPV_C_ACK) begin
				ack_tgl_q <= !ack_tgl_q;
			end
			if (rd_done) begin
				table_latch_q <= is_devid ? devid_byte : code_bar ? 8'h00 : i_mem_rdata;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_core_exec  <= 1'b0;
			o_core_instr <= '0;
			o_mem_rd     <= 1'b0;
			o_mem_wr     <= 1'b0;
			o_mem_wdata  <= '0;
			o_prog_start <= 1'b0;
		end else begin
			o_core_exec <= go && req_cmd_q == `SPPV_CMD_CORE;
			if (go && req_cmd_q == `SPPV_CMD_CORE) begin
				o_core_instr <= req_op_q;
			end
			o_mem_rd <= cst_q == SPPV_C_READ && !rd_local;
			o_mem_wr     <= wr_go;
			o_prog_start <= wr_go && req_cmd_q == `SPPV_CMD_WR_PROG;
			if (wr_go) begin
				o_mem_wdata <= req_op_q;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_table_ptr <= '0;
			o_mem_addr  <= '0;
			o_panel     <= '0;
			o_ram_rdata <= '0;
		end else begin
			o_table_ptr <= ptr_q;
			o_mem_addr  <= ptr_q;
			o_panel     <= ptr_q[`SPPV_BLOCK_MSB:`SPPV_PANEL_LSB];
			o_ram_rdata <= ram_rd;
		end
	end
endmodule

//--- tb/sppv_port_assertions.sv
// Concurrent checks of the serial program/verify port
`timescale 1ns/1ps
`include "sppv_defs.svh"
module sppv_port_assertions #(
	parameter logic [`SPPV_PTR_W-1:0] CODE_END = `SPPV_CODE_END_64K
) (
	input wire logic			i_core_clk,
	input wire logic			i_rst_n,
	input wire logic			i_serial_prog_clock,
	input wire logic			i_prog_enable_high,
	input wire logic			i_prog_enable_logic,
	input wire logic			i_lowvolt_select_pin,
	input wire logic			i_lowvolt_enable_bit,
	input wire logic [4:0]			i_code_protect,
	input wire logic			o_prog_mode,
	input wire logic			o_lowvolt_mode,
	input wire logic			o_unused_io_hiz,
	input wire logic			o_lowvolt_pin_dedicated,
	input wire logic			o_serial_prog_data_oe,
	input wire logic			o_core_exec,
	input wire logic [`SPPV_PTR_W-1:0]	o_mem_addr,
	input wire logic			o_mem_rd,
	input wire logic			o_mem_wr,
	input wire logic			o_prog_start,
	input wire logic			o_programming
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	wire logic [2:0] blk = {1'h0, o_mem_addr[15:14]} + 3'h1;
	wire logic boot = o_mem_addr[21:11] == 11'h000;
	wire logic prot_hit = o_mem_addr[21:16] == 6'h00
		&& (boot ? i_code_protect[0] : i_code_protect[blk]);

	AST_HIZ_MODE: assert property (o_unused_io_hiz == o_prog_mode)
		else $error("unused pins not floated with mode");
	AST_LV_PIN: assert property (o_lowvolt_pin_dedicated == o_lowvolt_mode)
		else $error("select pin not dedicated in low mode");
	AST_LV_ENTRY: assert property ($rose(o_lowvolt_mode)
		|-> i_lowvolt_enable_bit && i_lowvolt_select_pin && o_prog_mode)
		else $error("low mode entered without its conditions");
	AST_HV_ENTRY: assert property ($rose(i_prog_enable_high)
		&& !i_serial_prog_clock && !o_prog_mode |-> ##[1:6] o_prog_mode)
		else $error("high entry not taken");
	AST_EXIT: assert property ((!i_prog_enable_high && !i_prog_enable_logic) [*6]
		|-> !o_prog_mode)
		else $error("mode held without enable");
	AST_OE_MODE: assert property (o_serial_prog_data_oe |-> o_prog_mode)
		else $error("data driven outside mode");
	AST_EXEC: assert property (o_core_exec |-> o_prog_mode ##1 !o_core_exec)
		else $error("core execute pulse malformed");
	AST_PULSE: assert property ((o_mem_wr || o_mem_rd) |=> !(o_mem_wr || o_mem_rd))
		else $error("memory request longer than one cycle");
	AST_START: assert property (o_prog_start |-> o_mem_wr)
		else $error("start without write");
	AST_PROT: assert property (o_mem_wr |-> !prot_hit)
		else $error("write into protected block");
	AST_END: assert property (o_mem_wr
		|-> o_mem_addr[21:16] != 6'h00 || o_mem_addr <= CODE_END)
		else $error("write past code end");
	AST_PRG_END: assert property (!i_serial_prog_clock [*5] |-> !o_programming)
		else $error("programming outlives clock high");

	COV_LV: cover property ($rose(o_lowvolt_mode));
	COV_START: cover property (o_prog_start);
	COV_PRG: cover property ($rose(o_programming));
endmodule

bind sppv_port sppv_port_assertions #(.CODE_END(CODE_END)) u_sppv_port_assertions (
	.i_core_clk, .i_rst_n, .i_serial_prog_clock, .i_prog_enable_high,
	.i_prog_enable_logic, .i_lowvolt_select_pin, .i_lowvolt_enable_bit, .i_code_protect,
	.o_prog_mode, .o_lowvolt_mode, .o_unused_io_hiz, .o_lowvolt_pin_dedicated,
	.o_serial_prog_data_oe, .o_core_exec, .o_mem_addr, .o_mem_rd, .o_mem_wr,
	.o_prog_start, .o_programming);

//--- tb/sppv_programmer.sv
// Behavioural programmer driving the serial port pins
`timescale 1ns/1ps
module sppv_programmer (
	input  wire logic	i_pgd,
	output logic		o_clk,
	output logic		o_data,
	output logic		o_en_high,
	output logic		o_en_logic,
	output logic		o_sel
);
	initial begin
		o_clk = 1'b0;
		o_data = 1'b0;
		o_en_high = 1'b0;
		o_en_logic = 1'b0;
		o_sel = 1'b0;
	end
	task automatic enter(input logic lv);
		o_clk = 1'b0;
		o_data = 1'b0;
		o_sel = lv;
		#300;
		o_en_logic = lv;
		o_en_high = !lv;
		#400;
	endtask
	task automatic leave;
		o_en_high = 1'b0;
		o_en_logic = 1'b0;
		o_sel = 1'b0;
		#400;
	endtask
	task automatic frame(input logic [3:0] c, input logic [15:0] op, input int n,
		input int hold, output logic [7:0] rd);
		logic [19:0] b;
		logic rdc;
		b = {op, c};
		rdc = c[3:2] == 2'h2 || c == 4'h2;
		rd = 8'h00;
		for (int i = 0; i < n; i++) begin
			o_clk = 1'b1;
			// Released line toggles
			o_data = (rdc && i >= 12) ? ~o_data : b[i];
			#(40 + (i == 3 ? hold : 0));
			o_clk = 1'b0;
			if (rdc && i >= 12)
				rd[i-12] = i_pgd;
			#40;
		end
	endtask
endmodule

//--- tb/sppv_port_tb_top.sv
// Self-checking bench of the serial program/verify port
`timescale 1ns/1ps
`include "sppv_defs.svh"
module sppv_port_tb_top;
	logic		clk, rst_n, lowvolt_enable_bit, ram_wr, mem_valid, p_clk, p_data, en_h, en_l, sel;
	logic		sdo, oe, mode, lv, hiz, ded, exec, mem_rd, mem_wr, start, prgm, wr_st;
	logic [4:0]	prot;
	logic [2:0]	panel;
	logic [11:0]	ram_addr;
	logic [7:0]	ram_wdata, ram_rdata, mem_rdata, rd;
	logic [15:0]	instr, wdata, core_q, wr_data;
	logic [21:0]	tptr, maddr, wr_addr;
	int		n_mismatch, n_tests, n_wr, cycles, k;
	wire		serial_prog_data = oe ? sdo : p_data;
	logic [3:0]	rc [4] = '{4'h8, 4'h9, 4'ha, 4'hb};
	logic [3:0]	wc [4] = '{4'hc, 4'hd, 4'he, 4'hf};
	int		ro [4] = '{0, 0, 1, 1};
	int		po [4] = '{0, 1, 0, 1};
	int		wo [4] = '{0, 0, 2, 0};
	int		wp [4] = '{0, 2, 0, 0};
	logic [21:0]	sa [6] = '{22'h20_0000, 22'h30_0000, 22'h30_000d, 22'h3f_fffe,
		22'h3f_ffff, 22'h00_c000};
	logic [7:0]	se [6] = '{8'h5c, 8'h5c, 8'h51, 8'h34, 8'h12, 8'h00};
	logic [21:0]	pa [5] = '{22'h00_1234, 22'h00_0100, 22'h00_0800, 22'h00_c000,
		22'h20_0000};
	logic [4:0]	pp [5] = '{5'h1e, 5'h01, 5'h01, 5'h00, 5'h1f};
	int		pw [5] = '{0, 0, 1, 0, 1};

	// Arbitrary identification value
	sppv_port #(.CODE_END(`SPPV_CODE_END_48K), .DEVICE_ID(16'h1234)) u_sppv_port (
		.i_core_clk(clk), .i_rst_n(rst_n), .i_serial_prog_clock(p_clk),
		.i_serial_prog_data(serial_prog_data), .o_serial_prog_data(sdo), .o_serial_prog_data_oe(oe),
		.i_prog_enable_high(en_h), .i_prog_enable_logic(en_l), .i_lowvolt_select_pin(sel),
		.i_lowvolt_enable_bit(lowvolt_enable_bit), .i_code_protect(prot), .o_prog_mode(mode),
		.o_lowvolt_mode(lv), .o_unused_io_hiz(hiz), .o_lowvolt_pin_dedicated(ded),
		.o_core_exec(exec), .o_core_instr(instr), .i_ram_wr(ram_wr), .i_ram_addr(ram_addr),
		.i_ram_wdata(ram_wdata), .o_ram_rdata(ram_rdata), .o_table_ptr(tptr),
		.o_mem_addr(maddr), .o_panel(panel), .o_mem_rd(mem_rd), .i_mem_rdata(mem_rdata),
		.i_mem_rd_valid(mem_valid), .o_mem_wr(mem_wr), .o_mem_wdata(wdata),
		.o_prog_start(start), .o_programming(prgm));
	sppv_programmer u_sppv_programmer (.i_pgd(serial_prog_data), .o_clk(p_clk), .o_data(p_data),
		.o_en_high(en_h), .o_en_logic(en_l), .o_sel(sel));

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [21:0] e, input logic [21:0] s);
		n_tests++;
		if (s !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic ram_w(input logic [11:0] a, input logic [7:0] d);
		ram_wr = 1'b1;
		ram_addr = a;
		ram_wdata = d;
		cyc(1);
		ram_wr = 1'b0;
		cyc(1);
	endtask
	task automatic set_ptr(input logic [21:0] p);
		ram_w(12'hff8, {2'h0, p[21:16]});
		ram_w(12'hff7, p[15:8]);
		ram_w(12'hff6, p[7:0]);
		cyc(2);
		chk("ptr_set", p, tptr);
		chk("panel", p[15:13], panel);
	endtask
	task automatic fr(input logic [3:0] c, input logic [15:0] op);
		u_sppv_programmer.frame(c, op, 20, 0, rd);
		cyc(8);
	endtask

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Memory answers in the same cycle as a read; pulses are logged
	always @(posedge clk) begin
		#2;
		mem_valid = mem_rd;
		mem_rdata = maddr[7:0] ^ 8'h5c;
		if (mem_wr) begin
			n_wr++;
			wr_addr = maddr;
			wr_data = wdata;
			wr_st = start;
		end
		if (exec)
			core_q = instr;
		cycles++;
		if (cycles == 30000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	initial begin
		rst_n = 1'b0;
		lowvolt_enable_bit = 1'b0;
		prot = 5'h00;
		ram_wr = 1'b0;
		ram_addr = 12'h000;
		ram_wdata = 8'h00;
		repeat (20) @(posedge clk);
		#2;
		rst_n = 1'b1;
		cyc(1);
		chk("mode_rst", 1'b0, mode);
		u_sppv_programmer.enter(1'b1);
		chk("lv_refused", 1'b0, mode);
		u_sppv_programmer.leave();
		lowvolt_enable_bit = 1'b1;
		u_sppv_programmer.enter(1'b1);
		chk("lv_mode", 1'b1, lv);
		chk("lv_pin", 1'b1, ded);
		chk("hiz_lv", 1'b1, hiz);
		u_sppv_programmer.leave();
		chk("exit", 1'b0, mode);
		u_sppv_programmer.enter(1'b0);
		chk("hv_mode", 1'b1, mode);
		chk("hiz_hv", 1'b1, hiz);
		$display("test entry done");
		fr(4'h0, 16'h0e3c);
		chk("core", 16'h0e3c, core_q);
		ram_w(12'hff8, 8'hff);
		cyc(1);
		chk("upper", 8'h3f, ram_rdata);
		set_ptr(22'h00_1234);
		for (int i = 0; i < 4; i++) begin
			fr(rc[i], 16'h0000);
			chk("rd", 8'h34 + 8'(ro[i]) ^ 8'h5c, rd);
			chk("rd_ptr", 22'h00_1234 + 22'(po[i]), tptr);
		end
		fr(4'h2, 16'h0000);
		chk("latch", 8'h35 ^ 8'h5c, rd);
		$display("test reads done");
		for (int i = 0; i < 4; i++) begin
			k = n_wr;
			fr(wc[i], 16'h3c40 + 16'(i));
			chk("wr_cnt", 22'(k + 1), 22'(n_wr));
			// Pre-increment read left the pointer at 1235h
			chk("wr_addr", 22'h00_1235 + 22'(wo[i]), wr_addr);
			chk("wr_data", 16'h3c40 + 16'(i), wr_data);
			chk("wr_start", i == 3, wr_st);
			chk("wr_ptr", 22'h00_1235 + 22'(wp[i]), tptr);
		end
		fork
			u_sppv_programmer.frame(4'h0, 16'h0000, 20, 800, rd);
			begin
				#640;
				chk("prog_on", 1'b1, prgm);
			end
		join
		cyc(8);
		chk("prog_off", 1'b0, prgm);
		$display("test writes done");
		// ID and config touched after code work
		prot = 5'h1f;
		for (int i = 0; i < 6; i++) begin
			set_ptr(sa[i]);
			fr(4'h8, 16'h0000);
			chk("spot_rd", se[i], rd);
		end
		for (int i = 0; i < 5; i++) begin
			prot = pp[i];
			set_ptr(pa[i]);
			k = n_wr;
			fr(4'hc, 16'h5555);
			chk("prot_wr", 22'(k + pw[i]), 22'(n_wr));
		end
		$display("test protection done");
		u_sppv_programmer.frame(4'hf, 16'hffff, 2, 0, rd);
		u_sppv_programmer.leave();
		u_sppv_programmer.enter(1'b0);
		fr(4'h0, 16'hbeef);
		chk("core_after", 16'hbeef, core_q);
		$display("test abort done");
		wrap_up();
	end
endmodule
